// ===== core/odu_defs.vh
// Constants for the on-chip debug unit: APB offsets, field positions,
// reset values and serial timing. Assumes a 25 MHz ref_clk.
`ifndef ODU_DEFS_VH
`define ODU_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ODU_ADDR_CTRL      8'h00
`define ODU_ADDR_STAT      8'h04
`define ODU_ADDR_CNT       8'h08
`define ODU_ADDR_IRQ_STAT  8'h0C
`define ODU_ADDR_IRQ_MASK  8'h10
`define ODU_ADDR_TXDATA    8'h14
`define ODU_ADDR_RXDATA    8'h18
`define ODU_ADDR_BAUD      8'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ODU_CTRL_RST       0
`define ODU_CTRL_BZERO     1
`define ODU_CTRL_BPCMP     2
`define ODU_CTRL_HALT      7
`define ODU_STAT_IDLE      7
`define ODU_STAT_HALT      6
`define ODU_STAT_READ_PROTECT_FLAG      5
`define ODU_IRQ_BREAK      0
`define ODU_IRQ_RX         1
`define ODU_IRQ_TXDONE     2
`define ODU_IRQ_RSTDONE    3
`define ODU_RX_VALID       8
`define ODU_RX_TXBUSY      9

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define ODU_STAT_RST       8'h00
`define ODU_CNT_RST        16'h0000
`define ODU_CLK_HZ         25000000
`define ODU_BAUD_HZ        115200
`define ODU_BAUD_DIV_RST   (`ODU_CLK_HZ / `ODU_BAUD_HZ)

`endif

// ===== core/odu_serial.v
// Half-duplex 8N1 serial engine for the open-drain debug pin.
// Assumes an external pull-up; pin_i comes straight from the pad.
`timescale 1ns/1ps
module odu_serial (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [15:0] baud_div,
  input  wire        tx_start,
  input  wire [7:0]  tx_data,
  output wire        tx_ready,
  output reg         tx_done,
  output reg         rx_valid,
  output reg  [7:0]  rx_data,
  output wire        rx_active,
  input  wire        pin_i,
  output wire        pin_o,
  output wire        pin_oe
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_TX    = 2'b01;
  localparam [1:0] ST_RXSTA = 2'b10;
  localparam [1:0] ST_RXBIT = 2'b11;

  reg        sync1_q;
  reg        sync2_q;
  reg        prev_q;
  reg [1:0]  state_q;
  reg [15:0] baud_cnt_q;
  reg [3:0]  bit_cnt_q;
  reg [9:0]  shift_q;
  reg        drive_low_q;
  wire       fall;
  wire       tick;

  assign fall      = prev_q & ~sync2_q;
  assign tick      = (baud_cnt_q == 16'h0000);
  // One shared sequencer: receive and transmit cannot overlap
  assign tx_ready  = (state_q == ST_IDLE) & ~fall;
  assign rx_active = state_q[1];
  assign pin_o     = 1'b0;
  assign pin_oe    = drive_low_q;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q     <= 1'b1;
      sync2_q     <= 1'b1;
      prev_q      <= 1'b1;
      state_q     <= ST_IDLE;
      baud_cnt_q  <= 16'h0000;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 10'h3FF;
      drive_low_q <= 1'b0;
      tx_done     <= 1'b0;
      rx_valid    <= 1'b0;
      rx_data     <= 8'h00;
    end
    else
    begin
      sync1_q  <= pin_i;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      tx_done  <= 1'b0;
      rx_valid <= 1'b0;
      if (!tick)
        baud_cnt_q <= baud_cnt_q - 16'h0001;
      case (state_q)
        ST_IDLE:
        begin
          if (fall)
          begin
            state_q    <= ST_RXSTA;
            baud_cnt_q <= {1'b0, baud_div[15:1]};
          end
          else if (tx_start)
          begin
            state_q     <= ST_TX;
            shift_q     <= {1'b1, tx_data, 1'b0};
            bit_cnt_q   <= 4'h0;
            baud_cnt_q  <= baud_div - 16'h0001;
            drive_low_q <= 1'b1;
          end
        end
        ST_TX:
        begin
          if (tick)
          begin
            if (bit_cnt_q == 4'h9)
            begin
              state_q     <= ST_IDLE;
              drive_low_q <= 1'b0;
              tx_done     <= 1'b1;
            end
            else
            begin
              shift_q     <= {1'b1, shift_q[9:1]};
              bit_cnt_q   <= bit_cnt_q + 4'h1;
              drive_low_q <= ~shift_q[1];
              baud_cnt_q  <= baud_div - 16'h0001;
            end
          end
        end
        ST_RXSTA:
        begin
          // Start bit rechecked mid-bit to reject glitches
          if (tick)
          begin
            state_q    <= sync2_q ? ST_IDLE : ST_RXBIT;
            bit_cnt_q  <= 4'h0;
            baud_cnt_q <= baud_div - 16'h0001;
          end
        end
        ST_RXBIT:
        begin
          if (tick)
          begin
            baud_cnt_q <= baud_div - 16'h0001;
            if (bit_cnt_q == 4'h8)
            begin
              state_q <= ST_IDLE;
              // Framing error drops the byte
              if (sync2_q)
              begin
                rx_valid <= 1'b1;
                rx_data  <= shift_q[7:0];
              end
            end
            else
            begin
              shift_q   <= {2'b00, sync2_q, shift_q[7:1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // odu_serial

// ===== core/odu_top.v
// On-chip debug unit: debug counter, breakpoint, device reset request,
// status register and half-duplex serial link, behind an APB slave.
// Assumes CPU-side signals share ref_clk; the debug pin is asynchronous.
//
// Notes on behaviour
// - Debug pin carries traffic one way at a time, never both together.
// - Pin characters use start bit, eight data bits, stop bit framing.
// - Unit only pulls the pin low or releases it; pull-up gives high.
// - In breakpoint-compare setting the counter holds while the CPU runs.
// - Breakpoint-compare setting halts the CPU when PC equals the counter.
// - Break-on-zero sets the halt flag when the counter decrements to zero.
// - With break-on-zero the counter keeps its value on leaving debug mode.
// - Reset bit resets the device but leaves the debug unit intact.
// - Reset bit clears itself when the reset completes; writing 0 does nothing.
// - Status bit 7 shows halt flag or a break instruction since last control write.
// - Status bit 6 shows the device low-power halt state.
// - Status register is read-only, resets to zero, shows present state.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "odu_defs.vh"
module odu_top (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire [15:0] cpu_pc,
  input  wire        cpu_step,
  input  wire        cpu_brk_exec,
  input  wire        cpu_halt_mode,
  input  wire        read_protect_flag,
  input  wire        sys_reset_done,
  output reg         sys_reset_req,
  output reg         cpu_debug_halt,
  input  wire        debug_serial_pin_i,
  output wire        debug_serial_pin_o,
  output wire        debug_serial_pin_oe
);

  // Divisor reset value cut to the 16-bit register on purpose
  localparam [31:0] BAUD_RST_W = `ODU_BAUD_DIV_RST;
  localparam [15:0] BAUD_RST   = BAUD_RST_W[15:0];

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function reg_hit;
    input [7:0] a;
    begin
      case (a)
        `ODU_ADDR_CTRL,
        `ODU_ADDR_STAT,
        `ODU_ADDR_CNT,
        `ODU_ADDR_IRQ_STAT,
        `ODU_ADDR_IRQ_MASK,
        `ODU_ADDR_TXDATA,
        `ODU_ADDR_RXDATA,
        `ODU_ADDR_BAUD:
          reg_hit = 1'b1;
        default:
          reg_hit = 1'b0;
      endcase
    end
  endfunction

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr     = access & pwrite & reg_hit(paddr);
  wire rd     = access & ~pwrite & reg_hit(paddr);

  // Read data is latched in setup, so access always completes at once
  assign pready  = 1'b1;
  assign pslverr = access & ~reg_hit(paddr);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg        bzero_q;
  reg        bpcmp_q;
  reg        halt_q;
  reg        brk_seen_q;
  reg [15:0] cnt_q;
  reg [15:0] load_q;
  reg [7:0]  stat_q;
  reg [3:0]  irq_stat_q;
  reg [3:0]  irq_mask_q;
  reg [15:0] baud_q;
  reg [7:0]  rx_byte_q;
  reg        rx_full_q;
  reg [3:0]  cap_irq_q;
  reg        cap_rx_q;

  reg        halt_d;
  reg [15:0] cnt_d;

  wire       tx_ready;
  wire       tx_done;
  wire       rx_valid;
  wire [7:0] rx_data;
  wire       rx_active;

  wire ctrl_wr  = wr & (paddr == `ODU_ADDR_CTRL);
  wire cnt_wr   = wr & (paddr == `ODU_ADDR_CNT);
  wire tx_wr    = wr & (paddr == `ODU_ADDR_TXDATA);
  wire irq_rd   = rd & (paddr == `ODU_ADDR_IRQ_STAT);
  wire rx_rd    = rd & (paddr == `ODU_ADDR_RXDATA);
  // Dropped while the sequencer is busy or a start bit is pending
  wire tx_start = tx_wr & tx_ready;

  // ------------------------------------------------------------
  // Debug counter and halt flag
  // ------------------------------------------------------------
  wire bp_match  = bpcmp_q & ~halt_q & (cpu_pc == cnt_q);
  wire cnt_dec   = ~bpcmp_q & ~halt_q & cpu_step & (cnt_q != 16'h0000);
  wire hit_zero  = cnt_dec & bzero_q & (cnt_q == 16'h0001);

  always @*
  begin
    halt_d = halt_q;
    cnt_d  = cnt_q;
    if (cnt_dec)
      cnt_d = cnt_q - 16'h0001;
    if (ctrl_wr)
    begin
      halt_d = pwdata[`ODU_CTRL_HALT];
      // Leaving debug mode reloads the count unless break-on-zero is set
      if (halt_q && !pwdata[`ODU_CTRL_HALT] && !bzero_q)
        cnt_d = load_q;
    end
    // Set after the control write, so a break in the same cycle wins
    if (bp_match || hit_zero)
      halt_d = 1'b1;
    if (cnt_wr)
      cnt_d = pwdata[15:0];
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      halt_q         <= 1'b0;
      cnt_q          <= `ODU_CNT_RST;
      load_q         <= `ODU_CNT_RST;
      cpu_debug_halt <= 1'b0;
    end
    else
    begin
      halt_q         <= halt_d;
      cnt_q          <= cnt_d;
      cpu_debug_halt <= halt_d;
      if (cnt_wr)
        load_q <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Control bits and device reset request
  // ------------------------------------------------------------
  // Only resetn clears this block; the device reset it requests does not
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bzero_q       <= 1'b0;
      bpcmp_q       <= 1'b0;
      brk_seen_q    <= 1'b0;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        bzero_q <= pwdata[`ODU_CTRL_BZERO];
        bpcmp_q <= pwdata[`ODU_CTRL_BPCMP];
      end
      // A break in the same cycle as a control write still counts
      if (cpu_brk_exec)
        brk_seen_q <= 1'b1;
      else if (ctrl_wr)
        brk_seen_q <= 1'b0;
      // A new request in the completing cycle is kept
      if (ctrl_wr && pwdata[`ODU_CTRL_RST])
        sys_reset_req <= 1'b1;
      else if (sys_reset_done)
        sys_reset_req <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      stat_q <= `ODU_STAT_RST;
    else
    begin
      // Rebuilt each clock: only live sources reach it
      stat_q                 <= `ODU_STAT_RST;
      stat_q[`ODU_STAT_IDLE] <= halt_q | brk_seen_q;
      stat_q[`ODU_STAT_HALT] <= cpu_halt_mode;
      stat_q[`ODU_STAT_READ_PROTECT_FLAG] <= read_protect_flag;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status, mask and serial data holding
  // ------------------------------------------------------------
  // Halt event is the rising edge of the flag, whatever set it
  wire [3:0] irq_evt;
  assign irq_evt[`ODU_IRQ_BREAK]   = halt_d & ~halt_q;
  assign irq_evt[`ODU_IRQ_RX]      = rx_valid;
  assign irq_evt[`ODU_IRQ_TXDONE]  = tx_done;
  assign irq_evt[`ODU_IRQ_RSTDONE] = sys_reset_req & sys_reset_done;
  assign irq = |(irq_stat_q & irq_mask_q);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_irq
      // Read clears only what the read returned; a new event wins
      always @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
          irq_stat_q[g] <= 1'b0;
        else if (irq_evt[g])
          irq_stat_q[g] <= 1'b1;
        else if (irq_rd && cap_irq_q[g])
          irq_stat_q[g] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask_q <= 4'h0;
      baud_q     <= BAUD_RST;
      rx_byte_q  <= 8'h00;
      rx_full_q  <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `ODU_ADDR_IRQ_MASK)
        irq_mask_q <= pwdata[3:0];
      if (wr && paddr == `ODU_ADDR_BAUD && pwdata[15:0] != 16'h0000)
        baud_q <= pwdata[15:0];
      if (rx_valid)
      begin
        rx_byte_q <= rx_data;
        rx_full_q <= 1'b1;
      end
      else if (rx_rd && cap_rx_q)
        rx_full_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // APB read path
  // ------------------------------------------------------------
  reg [31:0] rdata_d;

  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `ODU_ADDR_CTRL:
      begin
        rdata_d[`ODU_CTRL_BZERO] = bzero_q;
        rdata_d[`ODU_CTRL_BPCMP] = bpcmp_q;
        rdata_d[`ODU_CTRL_HALT]  = halt_q;
        rdata_d[`ODU_CTRL_RST]   = sys_reset_req;
      end
      `ODU_ADDR_STAT:
        rdata_d[7:0] = stat_q;
      `ODU_ADDR_CNT:
        rdata_d[15:0] = cnt_q;
      `ODU_ADDR_IRQ_STAT:
        rdata_d[3:0] = irq_stat_q;
      `ODU_ADDR_IRQ_MASK:
        rdata_d[3:0] = irq_mask_q;
      `ODU_ADDR_RXDATA:
      begin
        rdata_d[7:0]             = rx_byte_q;
        rdata_d[`ODU_RX_VALID]   = rx_full_q;
        rdata_d[`ODU_RX_TXBUSY]  = ~tx_ready;
      end
      `ODU_ADDR_BAUD:
        rdata_d[15:0] = baud_q;
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata    <= 32'h0000_0000;
      cap_irq_q <= 4'h0;
      cap_rx_q  <= 1'b0;
    end
    // Captured in setup so prdata stays steady through access
    else if (setup)
    begin
      prdata    <= rdata_d;
      cap_irq_q <= irq_stat_q;
      cap_rx_q  <= rx_full_q;
    end
  end

  // ------------------------------------------------------------
  // Serial link on the debug pin
  // ------------------------------------------------------------
  // Bytes written while the link is busy are dropped; poll the busy bit
  odu_serial u_serial (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .baud_div  (baud_q),
    .tx_start  (tx_start),
    .tx_data   (pwdata[7:0]),
    .tx_ready  (tx_ready),
    .tx_done   (tx_done),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_active (rx_active),
    .pin_i     (debug_serial_pin_i),
    .pin_o     (debug_serial_pin_o),
    .pin_oe    (debug_serial_pin_oe)
  );

  // Reserved control bits are ignored on write and read as zero
  wire unused_ok = rx_active | (|pwdata[31:16]);

endmodule // odu_top

// ===== dv/odu_host_model.sv
// Host serial port on the open-drain debug pin, 8N1.
// Assumes a pull-up: pin reads high unless someone pulls low.
`timescale 1ns/1ps
module odu_host_model #(
  parameter int BAUD = 8
) (
  input  wire logic ref_clk,
  input  wire logic pin,
  output logic      host_low
);
  logic [7:0] got;
  int         got_n;
  int         ferr;
  logic       tx_act;
  initial
  begin
    host_low = 1'b0;
    tx_act = 1'b0;
    got_n = 0;
    ferr = 0;
  end
  // Caller sends only while the unit is silent
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    tx_act = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      host_low <= !f[i];
      repeat (BAUD) @(posedge ref_clk);
    end
    tx_act = 1'b0;
  endtask
  // Own frames are skipped: the line is half duplex
  always
  begin
    @(posedge ref_clk);
    if (!pin && !tx_act)
    begin
      repeat (BAUD / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BAUD) @(posedge ref_clk);
        got[i] = pin;
      end
      repeat (BAUD) @(posedge ref_clk);
      if (!pin)
        ferr++;
      got_n++;
    end
  end
endmodule // odu_host_model

// ===== dv/odu_top_assertions.sv
// Port-level assertions for the debug unit.
// Assumes one clock domain and the map in odu_defs.vh.
`timescale 1ns/1ps
`include "odu_defs.vh"
module odu_chk (
  input wire        ref_clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [15:0] cpu_pc,
  input wire        cpu_halt_mode,
  input wire        sys_reset_done,
  input wire        sys_reset_req,
  input wire        cpu_debug_halt,
  input wire        debug_serial_pin_i,
  input wire        debug_serial_pin_o,
  input wire        debug_serial_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire wr = psel && penable && pwrite;
  wire ctl_wr = wr && paddr == `ODU_ADDR_CTRL;
  wire st_rd = psel && penable && !pwrite && paddr == `ODU_ADDR_STAT;
  reg        bp_q;
  reg [15:0] cnt_q;
  // Shadow of compare setting; valid only while the counter holds
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      bp_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      if (ctl_wr)
        bp_q <= pwdata[`ODU_CTRL_BPCMP];
      if (wr && paddr == `ODU_ADDR_CNT)
        cnt_q <= pwdata[15:0];
    end
  sequence s_bp_hit;
    bp_q && cpu_pc == cnt_q && !cpu_debug_halt && !wr;
  endsequence
  sequence s_tx_wr;
    wr && paddr == `ODU_ADDR_TXDATA && !debug_serial_pin_oe && debug_serial_pin_i;
  endsequence
  property p_pin_od; !debug_serial_pin_o; endproperty
  property p_tx_start; s_tx_wr |-> ##[1:2] debug_serial_pin_oe; endproperty
  property p_rst_set; ctl_wr && pwdata[0] && !sys_reset_done |=> sys_reset_req; endproperty
  property p_rst_hold; sys_reset_req && !sys_reset_done |=> sys_reset_req; endproperty
  property p_rst_clr; sys_reset_req && sys_reset_done && !ctl_wr |=> !sys_reset_req; endproperty
  property p_bp_break; s_bp_hit |=> cpu_debug_halt; endproperty
  property p_stat_ro; st_rd |-> prdata[31:8] == 24'h00_0000 && prdata[4:0] == 5'h00; endproperty
  property p_stat_halt; st_rd |-> prdata[`ODU_STAT_HALT] == $past(cpu_halt_mode, 2); endproperty
  a_pin_od: assert property (p_pin_od) else $error("pin driven high");
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  a_rst_set: assert property (p_rst_set) else $error("reset request missing");
  a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
  a_rst_clr: assert property (p_rst_clr) else $error("reset request stuck");
  a_bp_break: assert property (p_bp_break) else $error("no breakpoint halt");
  a_stat_ro: assert property (p_stat_ro) else $error("status spare bits set");
  a_stat_halt: assert property (p_stat_halt) else $error("halt bit wrong");
endmodule // odu_chk
bind odu_top odu_chk u_chk (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .cpu_pc, .cpu_halt_mode, .sys_reset_done, .sys_reset_req, .cpu_debug_halt,
  .debug_serial_pin_i, .debug_serial_pin_o, .debug_serial_pin_oe);

// ===== dv/onchip_debug_unit_tb.sv
// Self-checking bench for odu_top with a host serial model.
// Assumes the register map and reset values of odu_defs.vh.
`timescale 1ns/1ps
`include "odu_defs.vh"
module onchip_debug_unit_tb;
  localparam int BAUD = 8;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, cpu_step, cpu_brk_exec;
  logic cpu_halt_mode, read_protect_flag, sys_reset_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [15:0] cpu_pc;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sys_reset_req, cpu_debug_halt, host_low;
  wire debug_serial_pin_o, debug_serial_pin_oe;
  logic rerr;
  int mismatches = 0;
  int n_compared = 0;
  wire debug_serial_pin_i = !((debug_serial_pin_oe && !debug_serial_pin_o) || host_low);
  odu_top uut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .cpu_pc, .cpu_step, .cpu_brk_exec, .cpu_halt_mode,
    .read_protect_flag, .sys_reset_done, .sys_reset_req, .cpu_debug_halt,
    .debug_serial_pin_i, .debug_serial_pin_o, .debug_serial_pin_oe);
  odu_host_model #(.BAUD(BAUD)) host (.ref_clk, .pin(debug_serial_pin_i), .host_low);
  always #20 ref_clk = ~ref_clk;
  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    chk(nm, 32'h0000_0001, 32'h0000_0000);
    test_done;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
      hang("pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      cpu_step <= 1'b1;
      @(posedge ref_clk);
      cpu_step <= 1'b0;
    end
  endtask
  task automatic t_regs;
    apb(0, `ODU_ADDR_STAT, 0);
    chk("stat", `ODU_STAT_RST, rdata);
    apb(0, `ODU_ADDR_BAUD, 0);
    chk("baud", `ODU_BAUD_DIV_RST, rdata);
    apb(1, `ODU_ADDR_STAT, 32'h0000_00FF);
    apb(0, `ODU_ADDR_STAT, 0);
    chk("stat wr", 0, rdata);
    apb(0, 8'h20, 0);
    chk("slverr", 1, rerr);
  endtask
  task automatic t_count;
    apb(1, `ODU_ADDR_IRQ_MASK, 0);
    apb(1, `ODU_ADDR_CNT, 2);
    apb(1, `ODU_ADDR_CTRL, 32'h0000_0002);
    step(1);
    apb(0, `ODU_ADDR_CNT, 0);
    chk("cnt", 1, rdata);
    step(1);
    @(negedge ref_clk);
    chk("halt", 1, cpu_debug_halt);
    chk("irq off", 0, irq);
    apb(1, `ODU_ADDR_IRQ_MASK, 1);
    @(negedge ref_clk);
    chk("irq on", 1, irq);
    apb(0, `ODU_ADDR_IRQ_STAT, 0);
    chk("irq stat", 1, rdata);
    @(negedge ref_clk);
    chk("irq clr", 0, irq);
    apb(1, `ODU_ADDR_CTRL, 32'h0000_0002);
    apb(0, `ODU_ADDR_CNT, 0);
    chk("cnt kept", 0, rdata);
    apb(1, `ODU_ADDR_CTRL, 0);
    step(1);
    apb(0, `ODU_ADDR_CNT, 0);
    chk("cnt floor", 0, rdata);
  endtask
  task automatic t_bp;
    apb(1, `ODU_ADDR_CNT, 32'h0000_0123);
    apb(1, `ODU_ADDR_CTRL, 32'h0000_0004);
    step(2);
    apb(0, `ODU_ADDR_CNT, 0);
    chk("cnt hold", 32'h0000_0123, rdata);
    @(posedge ref_clk);
    cpu_pc <= 16'h0123;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("bp halt", 1, cpu_debug_halt);
    apb(0, `ODU_ADDR_STAT, 0);
    chk("idle", 32'h0000_0080, rdata);
    cpu_pc <= 16'h0000;
    apb(1, `ODU_ADDR_CTRL, 0);
    apb(0, `ODU_ADDR_STAT, 0);
    chk("run", 0, rdata);
    cpu_brk_exec <= 1'b1;
    @(posedge ref_clk);
    cpu_brk_exec <= 1'b0;
    apb(0, `ODU_ADDR_STAT, 0);
    chk("brk", 32'h0000_0080, rdata);
    apb(1, `ODU_ADDR_CTRL, 0);
    apb(0, `ODU_ADDR_STAT, 0);
    chk("brk clr", 0, rdata);
  endtask
  task automatic t_stat;
    cpu_halt_mode <= 1'b1;
    read_protect_flag <= 1'b1;
    apb(0, `ODU_ADDR_STAT, 0);
    chk("halt bit", 32'h0000_0060, rdata);
    cpu_halt_mode <= 1'b0;
    read_protect_flag <= 1'b0;
    apb(0, `ODU_ADDR_STAT, 0);
    chk("stat now", 0, rdata);
  endtask
  task automatic t_rst;
    apb(1, `ODU_ADDR_CNT, 32'h0000_0055);
    apb(1, `ODU_ADDR_CTRL, 1);
    @(negedge ref_clk);
    chk("rst req", 1, sys_reset_req);
    apb(1, `ODU_ADDR_CTRL, 0);
    apb(0, `ODU_ADDR_CTRL, 0);
    chk("rst bit", 1, rdata[0]);
    sys_reset_done <= 1'b1;
    @(posedge ref_clk);
    sys_reset_done <= 1'b0;
    @(negedge ref_clk);
    chk("rst end", 0, sys_reset_req);
    apb(0, `ODU_ADDR_CNT, 0);
    chk("cnt intact", 32'h0000_0055, rdata);
  endtask
  task automatic t_link;
    int i;
    int n0;
    apb(1, `ODU_ADDR_BAUD, BAUD);
    n0 = host.got_n;
    apb(1, `ODU_ADDR_TXDATA, 32'h0000_00A5);
    apb(0, `ODU_ADDR_RXDATA, 0);
    chk("busy", 1, rdata[`ODU_RX_TXBUSY]);
    for (i = 0; i < 20 * BAUD && host.got_n == n0; i++)
      @(posedge ref_clk);
    if (host.got_n == n0)
      hang("tx byte");
    chk("tx byte", 32'h0000_00A5, host.got);
    chk("frame", 0, host.ferr);
    repeat (2 * BAUD) @(posedge ref_clk);
    host.send(8'h3C);
    i = 0;
    do
    begin
      apb(0, `ODU_ADDR_RXDATA, 0);
      i++;
    end
    while (rdata[`ODU_RX_VALID] !== 1'b1 && i < 20);
    if (rdata[`ODU_RX_VALID] !== 1'b1)
      hang("rx byte");
    chk("rx byte", 32'h0000_013C, rdata & 32'h0000_01FF);
    apb(0, `ODU_ADDR_IRQ_STAT, 0);
    chk("irq all", 32'h0000_000F, rdata);
    @(negedge ref_clk);
    chk("irq idle", 0, irq);
  endtask
  initial
  begin
    {psel, penable, pwrite, cpu_step, cpu_brk_exec} = 5'h00;
    {cpu_halt_mode, read_protect_flag, sys_reset_done} = 3'h0;
    {paddr, pwdata, cpu_pc} = 56'h00_0000_0000_0000;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs;
    t_count;
    t_bp;
    t_stat;
    t_rst;
    t_link;
    test_done;
  end
endmodule // onchip_debug_unit_tb
